// [core/omw_pkg.sv]
// Behaviour
// - four operating states driven by mode bits
// - sleep stops external and internal high oscillators
// - sleep and green halt instruction execution
// - opmode low bit set enters sleep
// - opmode field 10 enters green
// - clock select bit picks slow or normal
// - high stop bit stops oscillator in slow
// - sleep wakes on pin change, resumes normal
// - green wakes on pin or timer, returns back
// - sleep wakeup counts 2048 high clocks first
// - green wakeup resumes at once
// - enabled wake timer keeps counting in green
// - watchdog on: green runs from low RC
// - wake timer disabled: only pins wake green
// - opmode codes 00 normal 01 sleep 10 green
// - sleep also stops internal low RC
// - slow instruction cycle is low RC over four
// - port zero always wakes, port one per-bit enabled
package omw_pkg;

	// ****************************************
	// operating mode field
	// ****************************************
	localparam logic [1:0] OPMODE_NORMAL   = 2'h0;
	localparam logic [1:0] OPMODE_SLEEP    = 2'h1;
	localparam logic [1:0] OPMODE_GREEN    = 2'h2;
	localparam logic [1:0] OPMODE_RESERVED = 2'h3;
	localparam int         OPMODE_LOW_POS  = 0;
	localparam int         OPMODE_HIGH_POS = 1;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [1:0] OPMODE_RST   = 2'h0;
	localparam logic       CLKSEL_RST   = 1'h0;
	localparam logic       HOSTOP_RST   = 1'h0;
	localparam logic [7:0] PORT_RST     = 8'h00;

	// ****************************************
	// timing
	// ****************************************
	// high clocks counted after a sleep wakeup
	localparam logic [11:0] WAKE_STAB_CYCLES = 12'h800;
	// last divider count of a slow instruction cycle, counted from zero over four low RC edges
	localparam logic [1:0]  SLOW_DIV_LAST    = 2'h3;
	// software settle time before leaving slow with oscillator stopped
	localparam int          HIGH_OSC_SETTLE_MS = 10;

	// ****************************************
	// states
	// ****************************************
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_SLOW,
		ST_GREEN,
		ST_SLEEP,
		ST_WAKE_STAB
	} omw_state_t;

endpackage : omw_pkg

// [core/omw_mode_ctrl.sv]
module omw_mode_ctrl
	import omw_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// software write of the mode bits
	input  wire logic        mode_wr,
	input  wire logic [1:0]  wr_opmode_field,
	input  wire logic        wr_low_clock_select,
	input  wire logic        wr_high_osc_stop,
	// configuration levels
	input  wire logic [7:0]  port_one_wake_en,
	input  wire logic        wake_timer_enable,
	input  wire logic        second_timer_enable,
	input  wire logic        watchdog_enable,
	// asynchronous pins and low oscillator
	input  wire logic [7:0]  port_zero,
	input  wire logic [7:0]  port_one,
	input  wire logic        internal_low_rc_clk,
	// wake timer overflow, same clock
	input  wire logic        wake_timer_ovf,
	// mode bit readback
	output logic [1:0]       opmode_field,
	output logic             low_clock_select,
	output logic             high_osc_stop,
	// oscillator and clock controls
	output logic             external_high_osc_run,
	output logic             internal_high_rc_run,
	output logic             internal_low_rc_run,
	output logic             sys_clk_low,
	output logic             cpu_run,
	output logic             cpu_cycle_en,
	// timer and interrupt gating
	output logic             wake_timer_run,
	output logic             second_timer_run,
	output logic             irq_wake_timer_allow,
	output logic             irq_second_timer_allow,
	output logic             irq_external_allow,
	// status
	output logic [1:0]       op_state,
	output logic             wake_event
);

	// ****************************************
	// helpers
	// ****************************************
	// low-power states where the cpu is halted
	function automatic logic is_halted(input omw_state_t s);
		is_halted = (s == ST_GREEN) || (s == ST_SLEEP) || (s == ST_WAKE_STAB);
	endfunction : is_halted

	// sleep or its oscillator settling tail
	function automatic logic is_asleep(input omw_state_t s);
		is_asleep = (s == ST_SLEEP) || (s == ST_WAKE_STAB);
	endfunction : is_asleep

	// ****************************************
	// pin synchronisers
	// ****************************************
	localparam int NSYNC = 17;

	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic [NSYNC-1:0] sync3_r;
	logic [NSYNC-1:0] stable_r;
	logic [NSYNC-1:0] stable_nxt;
	logic [NSYNC-1:0] raw_in;

	assign raw_in = {internal_low_rc_clk, port_one, port_zero};

	// a level is taken only once the last two stages agree, filtering glitches
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_agree
			assign stable_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi]
				: stable_r[gi];
		end
	endgenerate

	// sync chain, reset to a quiet level
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sync1_r  <= '0;
			sync2_r  <= '0;
			sync3_r  <= '0;
			stable_r <= '0;
		end else begin
			sync1_r  <= raw_in;
			sync2_r  <= sync1_r;
			sync3_r  <= sync2_r;
			stable_r <= stable_nxt;
		end
	end

	logic [15:0] pin_delta;
	logic        pin_wake;
	logic        low_rc_rise;

	// port zero is always armed, port one bit by bit
	assign pin_delta   = stable_nxt[15:0] ^ stable_r[15:0];
	assign pin_wake    = |(pin_delta & {port_one_wake_en, 8'hFF});
	assign low_rc_rise = stable_nxt[16] & ~stable_r[16];

	// ****************************************
	// mode bits and state
	// ****************************************
	omw_state_t  state_r;
	omw_state_t  state_nxt;
	logic [1:0]  opmode_r;
	logic [1:0]  opmode_nxt;
	logic        clksel_r;
	logic        clksel_nxt;
	logic        hostop_r;
	logic        hostop_nxt;
	logic [11:0] stab_cnt_r;
	logic [11:0] stab_cnt_nxt;
	logic        wake_r;
	logic        wake_nxt;
	logic        green_wake;

	// timer overflow only counts while the wake timer is enabled
	assign green_wake = pin_wake || (wake_timer_enable && wake_timer_ovf);

	// next state and mode bits
	always_comb begin
		state_nxt    = state_r;
		opmode_nxt   = opmode_r;
		clksel_nxt   = clksel_r;
		hostop_nxt   = hostop_r;
		stab_cnt_nxt = stab_cnt_r;
		wake_nxt     = 1'b0;
		unique case (state_r)
			ST_NORMAL, ST_SLOW: begin
				// writes are only possible while the cpu executes
				if (mode_wr) begin
					clksel_nxt = wr_low_clock_select;
					hostop_nxt = wr_high_osc_stop;
					opmode_nxt = wr_opmode_field;
				end
				// low bit wins, so the reserved code falls back to sleep
				if (mode_wr && wr_opmode_field[OPMODE_LOW_POS]) begin
					state_nxt = ST_SLEEP;
				end else if (mode_wr && wr_opmode_field == OPMODE_GREEN) begin
					state_nxt = ST_GREEN;
				end else if (mode_wr) begin
					state_nxt = wr_low_clock_select ? ST_SLOW : ST_NORMAL;
				end
			end
			ST_GREEN: begin
				if (green_wake) begin
					// back to the run state the clock select bit picks, no settling
					state_nxt  = clksel_r ? ST_SLOW : ST_NORMAL;
					opmode_nxt = OPMODE_NORMAL;
					wake_nxt   = 1'b1;
				end
			end
			ST_SLEEP: begin
				// only a pin change; reset is handled by the reset branch
				if (pin_wake) begin
					state_nxt    = ST_WAKE_STAB;
					stab_cnt_nxt = '0;
				end
			end
			ST_WAKE_STAB: begin
				if (stab_cnt_r == WAKE_STAB_CYCLES - 12'h001) begin
					state_nxt  = ST_NORMAL;
					opmode_nxt = OPMODE_NORMAL;
					clksel_nxt = 1'b0;
					hostop_nxt = 1'b0;
					wake_nxt   = 1'b1;
				end else begin
					stab_cnt_nxt = stab_cnt_r + 12'h001;
				end
			end
			default: begin
				state_nxt = ST_NORMAL;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r    <= ST_NORMAL;
			opmode_r   <= OPMODE_RST;
			clksel_r   <= CLKSEL_RST;
			hostop_r   <= HOSTOP_RST;
			stab_cnt_r <= '0;
			wake_r     <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			opmode_r   <= opmode_nxt;
			clksel_r   <= clksel_nxt;
			hostop_r   <= hostop_nxt;
			stab_cnt_r <= stab_cnt_nxt;
			wake_r     <= wake_nxt;
		end
	end

	// ****************************************
	// slow instruction cycle divider
	// ****************************************
	logic [1:0] div_r;
	logic [1:0] div_nxt;
	logic       slow_tick;

	// one instruction cycle per four low RC edges
	always_comb begin
		div_nxt   = div_r;
		slow_tick = 1'b0;
		if (state_r != ST_SLOW) begin
			div_nxt = '0;
		end else if (low_rc_rise) begin
			div_nxt   = (div_r == SLOW_DIV_LAST) ? 2'h0 : div_r + 2'h1;
			slow_tick = (div_r == SLOW_DIV_LAST);
		end
	end

	// divider register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_r <= '0;
		end else begin
			div_r <= div_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign opmode_field     = opmode_r;
	assign low_clock_select = clksel_r;
	assign high_osc_stop    = hostop_r;
	assign wake_event       = wake_r;

	// high oscillators: stopped in sleep, stoppable in slow and green
	always_comb begin
		external_high_osc_run = 1'b1;
		if (state_r == ST_SLEEP) begin
			external_high_osc_run = 1'b0;
		end else if ((state_r == ST_SLOW || state_r == ST_GREEN) && hostop_r) begin
			external_high_osc_run = 1'b0;
		end
	end
	assign internal_high_rc_run = external_high_osc_run;

	// low RC dies only in sleep, the settling count needs only the high clock
	assign internal_low_rc_run = !is_asleep(state_r);

	// cpu halt and clock source
	always_comb begin
		cpu_run      = !is_halted(state_r);
		sys_clk_low  = 1'b0;
		cpu_cycle_en = 1'b0;
		unique case (state_r)
			ST_NORMAL: begin
				// full speed: an instruction cycle on every edge
				cpu_cycle_en = 1'b1;
			end
			ST_SLOW: begin
				sys_clk_low  = 1'b1;
				cpu_cycle_en = slow_tick;
			end
			ST_GREEN: begin
				// a running watchdog needs the low clock even when normal was left
				sys_clk_low = clksel_r || watchdog_enable;
			end
			default: begin
				// sleep and settling stay on the high clock, cpu halted
				sys_clk_low = 1'b0;
			end
		endcase
	end

	// timers and interrupt sources per state
	always_comb begin
		wake_timer_run         = wake_timer_enable;
		second_timer_run       = second_timer_enable;
		irq_wake_timer_allow   = 1'b1;
		irq_second_timer_allow = 1'b1;
		irq_external_allow     = 1'b1;
		// halted: nothing for the second timer to serve, so it waits with the cpu
		if (is_halted(state_r)) begin
			second_timer_run       = 1'b0;
			irq_second_timer_allow = 1'b0;
		end
		// asleep: the wake timer freezes too and no interrupt can be taken
		if (is_asleep(state_r)) begin
			wake_timer_run       = 1'b0;
			irq_wake_timer_allow = 1'b0;
			irq_external_allow   = 1'b0;
		end
	end

	// reported mode, settling reads as sleep
	always_comb begin
		unique case (state_r)
			ST_GREEN:     op_state = OPMODE_GREEN;
			ST_SLEEP:     op_state = OPMODE_SLEEP;
			ST_WAKE_STAB: op_state = OPMODE_SLEEP;
			default:      op_state = OPMODE_NORMAL;
		endcase
	end

endmodule : omw_mode_ctrl

// [sim/omw_monitor.sv]
module omw_monitor
	import omw_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_b,
	// stimulus side
	input wire logic       mode_wr,
	input wire logic [1:0] wr_opmode_field,
	input wire logic       wake_timer_enable,
	input wire logic       wake_timer_ovf,
	input wire logic       watchdog_enable,
	// design outputs
	input wire logic [1:0] op_state,
	input wire logic [1:0] opmode_field,
	input wire logic       low_clock_select,
	input wire logic       high_osc_stop,
	input wire logic       external_high_osc_run,
	input wire logic       internal_high_rc_run,
	input wire logic       internal_low_rc_run,
	input wire logic       sys_clk_low,
	input wire logic       cpu_run,
	input wire logic       wake_timer_run,
	input wire logic       second_timer_run,
	input wire logic       cpu_cycle_en,
	input wire logic       irq_wake_timer_allow,
	input wire logic       irq_second_timer_allow,
	input wire logic       irq_external_allow,
	input wire logic       wake_event
);
	logic [12:0] stab_cnt_r;
	logic [12:0] stab_cnt_nxt;
	// counts settling cycles; repeats of a flop would prove nothing
	always_comb begin
		stab_cnt_nxt = (op_state == OPMODE_SLEEP && external_high_osc_run) ?
			stab_cnt_r + 13'h0001 : 13'h0000;
	end
	always_ff @(posedge clk) begin
		stab_cnt_r <= rst_b ? stab_cnt_nxt : 13'h0000;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ****************
	// assertions
	// ****************
	sleep_halt_a: assert property (
		op_state == OPMODE_SLEEP && !external_high_osc_run |-> !cpu_run &&
		!internal_low_rc_run && !wake_timer_run && !second_timer_run)
		else $error("sleep left something running");
	sleep_osc_a: assert property (
		$rose(op_state == OPMODE_SLEEP) |-> !external_high_osc_run && !internal_high_rc_run)
		else $error("high oscillators run in sleep");
	green_halt_a: assert property (
		op_state == OPMODE_GREEN |-> !cpu_run && internal_low_rc_run && !second_timer_run)
		else $error("green state gating wrong");
	enter_sleep_a: assert property (
		mode_wr && op_state == OPMODE_NORMAL && wr_opmode_field[0] |=> op_state == OPMODE_SLEEP)
		else $error("sleep not entered");
	enter_green_a: assert property (
		mode_wr && op_state == OPMODE_NORMAL && wr_opmode_field == OPMODE_GREEN
		|=> op_state == OPMODE_GREEN && opmode_field == OPMODE_GREEN)
		else $error("green not entered");
	clk_sel_a: assert property (
		op_state == OPMODE_NORMAL |-> sys_clk_low == low_clock_select &&
		external_high_osc_run == !(low_clock_select && high_osc_stop))
		else $error("clock select or stop wrong");
	stab_time_a: assert property (
		op_state == OPMODE_NORMAL && $past(op_state) == OPMODE_SLEEP
		|-> stab_cnt_r == {1'b0, WAKE_STAB_CYCLES} && wake_event && !low_clock_select)
		else $error("sleep wakeup count wrong");
	green_wake_a: assert property (
		op_state == OPMODE_GREEN && wake_timer_enable && wake_timer_ovf
		|=> op_state == OPMODE_NORMAL && wake_event && cpu_run)
		else $error("timer wake from green failed");
	wdog_green_a: assert property (
		op_state == OPMODE_GREEN && watchdog_enable |-> sys_clk_low)
		else $error("green with watchdog not on low clock");
	green_timer_a: assert property (
		op_state == OPMODE_GREEN |-> wake_timer_run == wake_timer_enable)
		else $error("wake timer gating wrong in green");
	irq_gate_a: assert property (
		irq_second_timer_allow == (op_state == OPMODE_NORMAL) &&
		irq_wake_timer_allow == (op_state != OPMODE_SLEEP) &&
		irq_external_allow == (op_state != OPMODE_SLEEP))
		else $error("interrupt gating wrong for state");
	cycle_rate_a: assert property (
		op_state == OPMODE_NORMAL && !sys_clk_low |-> cpu_cycle_en)
		else $error("normal state missed an instruction cycle");
	// main scenarios
	cover property (stab_cnt_r == {1'b0, WAKE_STAB_CYCLES});
	cover property (op_state == OPMODE_NORMAL && sys_clk_low && cpu_cycle_en);
	cover property (op_state == OPMODE_GREEN && wake_timer_ovf);
	cover property (op_state == OPMODE_NORMAL && sys_clk_low);
endmodule : omw_monitor

bind omw_mode_ctrl omw_monitor omw_monitor_inst (
	.clk(clk), .rst_b(rst_b), .mode_wr(mode_wr), .wr_opmode_field(wr_opmode_field),
	.wake_timer_enable(wake_timer_enable), .wake_timer_ovf(wake_timer_ovf),
	.watchdog_enable(watchdog_enable), .op_state(op_state), .opmode_field(opmode_field),
	.low_clock_select(low_clock_select), .high_osc_stop(high_osc_stop),
	.external_high_osc_run(external_high_osc_run), .internal_high_rc_run(internal_high_rc_run),
	.internal_low_rc_run(internal_low_rc_run), .sys_clk_low(sys_clk_low), .cpu_run(cpu_run),
	.wake_timer_run(wake_timer_run), .second_timer_run(second_timer_run),
	.cpu_cycle_en(cpu_cycle_en), .irq_wake_timer_allow(irq_wake_timer_allow),
	.irq_second_timer_allow(irq_second_timer_allow), .irq_external_allow(irq_external_allow),
	.wake_event(wake_event)
);

// [sim/omw_partner.sv]
module omw_partner (
	// system clock
	input  wire logic clk,
	// oscillator run level from the design
	input  wire logic run_en,
	// far side outputs
	output logic      low_rc_clk,
	output logic      timer_ovf
);
	timeunit 1ns;
	timeprecision 1ns;
	// low rc parks low while the design holds it off; phase unrelated to clk
	initial begin
		low_rc_clk = 1'b0;
		forever #411 low_rc_clk = (run_en === 1'b0) ? 1'b0 : ~low_rc_clk;
	end
	initial timer_ovf = 1'b0;
	// one clk wide overflow, launched off the falling edge
	task automatic fire_ovf();
		@(negedge clk);
		timer_ovf = 1'b1;
		@(negedge clk);
		timer_ovf = 1'b0;
	endtask : fire_ovf
endmodule : omw_partner

// [sim/omw_mode_ctrl_tb_top.sv]
module omw_mode_ctrl_tb_top
	import omw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SETTLE = 64; // shortened oscillator settle wait
	logic       clk, rst_b, mode_wr, lcs_w, hos_w, wt_en, st_en, wd_en, lrc, ovf;
	logic [1:0] field_w, op_state, opmode_field;
	logic [7:0] p0, p1, p1_en;
	logic       lcs, hos, ext_run, sys_low, cpu_run, cyc_en, st_run, wake_ev, lrc_run;
	int         err_count, num_checks, n;
	int         en_cnt = 0;
	logic [5:0] r;
	// rows: field, clock select, stop, expected state
	logic [5:0] rows [8] = '{6'h08, 6'h0C, 6'h08, 6'h00, 6'h22, 6'h2A, 6'h11, 6'h39};

	omw_mode_ctrl omw_mode_ctrl_inst (
		.clk(clk), .rst_b(rst_b), .mode_wr(mode_wr), .wr_opmode_field(field_w),
		.wr_low_clock_select(lcs_w), .wr_high_osc_stop(hos_w), .port_one_wake_en(p1_en),
		.wake_timer_enable(wt_en), .second_timer_enable(st_en), .watchdog_enable(wd_en),
		.port_zero(p0), .port_one(p1), .internal_low_rc_clk(lrc), .wake_timer_ovf(ovf),
		.opmode_field(opmode_field), .low_clock_select(lcs), .high_osc_stop(hos),
		.external_high_osc_run(ext_run), .internal_high_rc_run(), .internal_low_rc_run(lrc_run),
		.sys_clk_low(sys_low), .cpu_run(cpu_run), .cpu_cycle_en(cyc_en),
		.wake_timer_run(), .second_timer_run(st_run), .irq_wake_timer_allow(),
		.irq_second_timer_allow(), .irq_external_allow(), .op_state(op_state),
		.wake_event(wake_ev)
	);
	omw_partner omw_partner_inst (.clk(clk), .run_en(lrc_run), .low_rc_clk(lrc), .timer_ovf(ovf));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (cyc_en === 1'b1) en_cnt++;
	end
	task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one-cycle write pulse, all three bits together
	task automatic wr(input logic [1:0] f, input logic c, input logic s);
		@(negedge clk);
		{mode_wr, field_w, lcs_w, hos_w} = {1'b1, f, c, s};
		@(negedge clk);
		mode_wr = 1'b0;
	endtask : wr
	// flip pins, then wait boundedly for the wakeup pulse
	task automatic wake(input logic [7:0] m0, input logic [7:0] m1);
		@(negedge clk);
		p0 = p0 ^ m0;
		p1 = p1 ^ m1;
		n = 0;
		while (wake_ev !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask : wake
	task automatic end_sim();
		if (err_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	initial begin
		{rst_b, mode_wr, field_w, lcs_w, hos_w, wt_en, wd_en} = '0;
		{p0, p1, p1_en} = '0;
		st_en = 1'b1;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk(opmode_field, 2'h0);
		chk({lcs, hos}, 2'h0);
		chk(2'(cpu_run), 2'h1);
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			wr(r[5:4], r[3], r[2]);
			chk(op_state, r[1:0]);
			chk(2'(cpu_run), 2'(r[1:0] == 2'h0));
			chk(2'(st_run), 2'(r[1:0] == 2'h0));
			chk(2'(ext_run), 2'(r[1:0] != OPMODE_SLEEP && !(r[3] && r[2])));
			if (i == 2) repeat (SETTLE) @(negedge clk);
			if (r[1:0] != 2'h0) begin
				wake(8'h01 << i, 8'h00);
				chk(op_state, 2'h0);
				chk(2'(lcs), 2'(r[1:0] == OPMODE_GREEN && r[3]));
			end
		end
		// green refuses writes; timer wakes only when enabled
		wd_en = 1'b1;
		wr(OPMODE_GREEN, 1'b0, 1'b0);
		chk(2'(sys_low), 2'h1);
		wr(OPMODE_SLEEP, 1'b0, 1'b0);
		omw_partner_inst.fire_ovf();
		repeat (4) @(negedge clk);
		chk(op_state, OPMODE_GREEN);
		wt_en = 1'b1;
		omw_partner_inst.fire_ovf();
		chk(op_state, 2'h0);
		chk(2'(wake_ev), 2'h1);
		// port one pin needs its enable; sleep wake waits the count
		wd_en = 1'b0;
		wr(OPMODE_SLEEP, 1'b0, 1'b0);
		p1[3] = 1'b1;
		repeat (20) @(negedge clk);
		chk(op_state, OPMODE_SLEEP);
		p1_en = 8'h08;
		wake(8'h00, 8'h08);
		chk(2'(n >= 2049 && n <= 2060), 2'h1);
		// reset in mid-sleep: straight back to normal, no settling count
		wr(OPMODE_SLEEP, 1'b1, 1'b1);
		repeat (8) @(negedge clk);
		chk(op_state, OPMODE_SLEEP);
		chk(2'(lrc_run), 2'h0);
		rst_b = 1'b0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk(op_state, OPMODE_NORMAL);
		chk({lcs, hos}, 2'h0);
		chk({ext_run, cpu_run}, 2'h3);
		chk({wake_ev, lrc_run}, 2'h1);
		// second timer follows its enable while running
		st_en = 1'b0;
		@(negedge clk);
		chk(2'(st_run), 2'h0);
		st_en = 1'b1;
		// slow: one instruction cycle per four low rc edges
		wr(OPMODE_NORMAL, 1'b1, 1'b0);
		n = en_cnt;
		repeat (64) @(posedge lrc);
		chk(2'(en_cnt - n >= 15 && en_cnt - n <= 17), 2'h1);
		end_sim();
	end
	// cut a hang short
	initial begin
		#1500000;
		err_count++;
		end_sim();
	end
endmodule : omw_mode_ctrl_tb_top
